// *** rtl/mtrc_range_checker.sv ***
`timescale 1ns/1ps
`include "mtrc_regs.svh"

// Summary of operation
// - uncacheable range: reads from memory, no line fill; writes go out without allocate
// - write-combining range: reads uncached; writes may merge in the merge buffer
// - both ranges live in one 64-bit register cleared at reset
// - low 32 bits describe range 0, high 32 bits describe range 1
// - base field is address bits 31:17; low 17 bits implied zero
// - address is in range when mask&base equals mask&address upper bits
// - uncacheable bit wins; combine bit alone means write-combining; neither means no effect
// - range 0 type bits at 0 and 1, range 1 at 32 and 33
// - mask sets range size: all ones 128 Kbytes, all zeros 4 Gbytes
// - write-combining writes merge into an 8-byte buffer, leaving as one write
// - speculative ordering disable: strong ordering except for uncacheable or combining writes
module mtrc_range_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic msrWrite,
    input wire logic msrRead,
    input wire logic [31:0] msrAddr,
    input wire logic [63:0] msrWdata,
    output logic [63:0] msrRdata,
    output logic msrAck,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [31:0] reqAddr,
    input wire logic [3:0] reqBe,
    input wire logic [31:0] reqData,
    input wire logic globalOrderingDisable,
    input wire logic speculativeOrderingDisable,
    input wire logic mergeFlush,
    output logic rspValid,
    output mtrc_pkg::mtrc_mtype_t rspType,
    output logic rspUncacheable,
    output logic rspWriteCombine,
    output logic rspNoAllocate,
    output logic rspMerged,
    output logic rspStrongOrder,
    output logic [1:0] rspRangeHit,
    output logic busWrValid,
    output logic [28:0] busWrAddr,
    output logic [63:0] busWrData,
    output logic [7:0] busWrBe
);
    import mtrc_pkg::*;

    logic [63:0] rangeCtrl_q, rangeCtrl_d;
    logic [1:0] hit, rangeUc, rangeWc;
    logic isUc, isWc, mergeNow, flushNow, msrSel;
    mtrc_mtype_t mtype;
    logic [63:0] msrRdata_d;
    logic msrAck_d;
    logic rspValid_d, rspUc_d, rspWc_d, rspNoAlloc_d, rspMerged_d, rspStrong_d;
    mtrc_mtype_t rspType_d;
    logic [1:0] rspHit_d;

    // per-range match and type decode
    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_range
            localparam int unsigned LO = i * `MTRC_HALF_W;
            logic [14:0] baseField;
            logic [14:0] maskField;
            logic ucBit;
            logic wcBit;
            assign baseField = rangeCtrl_q[LO + `MTRC_BASE_LSB +: `MTRC_FIELD_W];
            assign maskField = rangeCtrl_q[LO + `MTRC_MASK_LSB +: `MTRC_FIELD_W];
            assign ucBit = rangeCtrl_q[LO + `MTRC_UC_BIT];
            assign wcBit = rangeCtrl_q[LO + `MTRC_WC_BIT];
            assign hit[i] = (maskField & baseField) == (maskField & reqAddr[`MTRC_ADDR_LSB +: `MTRC_FIELD_W]);
            assign rangeUc[i] = hit[i] & ucBit;
            assign rangeWc[i] = hit[i] & wcBit & ~ucBit;
        end
    endgenerate

    // classification straight from the live register
    always_comb
    begin
        isUc = |rangeUc;
        isWc = !isUc && (|rangeWc);
        if (isUc)
        begin
            mtype = MTRC_MT_UC;
        end
        else if (isWc)
        begin
            mtype = MTRC_MT_WC;
        end
        else
        begin
            mtype = MTRC_MT_NONE;
        end
        mergeNow = reqValid && reqWrite && isWc && (reqBe != 4'h0);
        // any other access drains the buffer first to keep order
        flushNow = mergeFlush || (reqValid && !mergeNow);
    end

    // register access and response
    assign msrSel = msrAddr == `MTRC_MSR_ADDR;

    always_comb
    begin
        rangeCtrl_d = rangeCtrl_q;
        msrRdata_d = 64'h0;
        msrAck_d = 1'b0;
        if (msrWrite && msrSel)
        begin
            rangeCtrl_d = msrWdata;
            msrAck_d = 1'b1;
        end
        else if (msrRead && msrSel)
        begin
            msrRdata_d = rangeCtrl_q;
            msrAck_d = 1'b1;
        end
        rspValid_d = reqValid;
        rspType_d = reqValid ? mtype : MTRC_MT_NONE;
        rspUc_d = reqValid && isUc;
        rspWc_d = reqValid && isWc;
        rspNoAlloc_d = reqValid && (isUc || isWc);
        rspMerged_d = mergeNow;
        rspHit_d = reqValid ? hit : 2'b00;
        if (!reqValid || !reqWrite || globalOrderingDisable)
        begin
            rspStrong_d = 1'b0;
        end
        else if (speculativeOrderingDisable)
        begin
            rspStrong_d = !(isUc || isWc);
        end
        else
        begin
            rspStrong_d = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rangeCtrl_q <= `MTRC_CTRL_RESET;
            msrRdata <= 64'h0;
            msrAck <= 1'b0;
            rspValid <= 1'b0;
            rspType <= MTRC_MT_NONE;
            rspUncacheable <= 1'b0;
            rspWriteCombine <= 1'b0;
            rspNoAllocate <= 1'b0;
            rspMerged <= 1'b0;
            rspStrongOrder <= 1'b0;
            rspRangeHit <= 2'b00;
        end
        else if (ce)
        begin
            rangeCtrl_q <= rangeCtrl_d;
            msrRdata <= msrRdata_d;
            msrAck <= msrAck_d;
            rspValid <= rspValid_d;
            rspType <= rspType_d;
            rspUncacheable <= rspUc_d;
            rspWriteCombine <= rspWc_d;
            rspNoAllocate <= rspNoAlloc_d;
            rspMerged <= rspMerged_d;
            rspStrongOrder <= rspStrong_d;
            rspRangeHit <= rspHit_d;
        end
    end

    mtrc_merge_buffer u_merge (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .mergeEn(mergeNow),
        .flush(flushNow),
        .addr(reqAddr),
        .be(reqBe),
        .data(reqData),
        .outValid(busWrValid),
        .outAddr(busWrAddr),
        .outData(busWrData),
        .outBe(busWrBe)
    );

    // checks
    logic [1:0] expectHit;
    assign expectHit[0] = ((rangeCtrl_q[`MTRC_MASK_LSB +: `MTRC_FIELD_W] ^ 15'h7fff) | 15'h0) != 15'h0
        ? (((rangeCtrl_q[`MTRC_BASE_LSB +: `MTRC_FIELD_W] ^ reqAddr[31:`MTRC_ADDR_LSB])
            & rangeCtrl_q[`MTRC_MASK_LSB +: `MTRC_FIELD_W]) == 15'h0)
        : (rangeCtrl_q[`MTRC_BASE_LSB +: `MTRC_FIELD_W] == reqAddr[31:`MTRC_ADDR_LSB]);
    assign expectHit[1] = ((rangeCtrl_q[`MTRC_HALF_W + `MTRC_BASE_LSB +: `MTRC_FIELD_W] ^ reqAddr[31:`MTRC_ADDR_LSB])
        & rangeCtrl_q[`MTRC_HALF_W + `MTRC_MASK_LSB +: `MTRC_FIELD_W]) == 15'h0;

    property p_reset_clear;
        @(posedge clock) disable iff (rst)
        $past(rst) |-> (rangeCtrl_q == `MTRC_CTRL_RESET) && !rspValid && !busWrValid;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("register not clear after reset");

    property p_match;
        @(posedge clock) disable iff (rst)
        $past(ce && reqValid) |-> rspValid && (rspRangeHit == $past(expectHit));
    endproperty
    a_match: assert property (p_match) else $error("range match wrong");

    property p_uc_no_alloc;
        @(posedge clock) disable iff (rst)
        rspUncacheable |-> rspNoAllocate && !rspMerged && (rspType == MTRC_MT_UC);
    endproperty
    a_uc_no_alloc: assert property (p_uc_no_alloc) else $error("uncacheable access allocates");

    property p_wc_no_alloc;
        @(posedge clock) disable iff (rst)
        rspWriteCombine |-> rspNoAllocate && !rspUncacheable;
    endproperty
    a_wc_no_alloc: assert property (p_wc_no_alloc) else $error("combining access allocates");

    property p_range1_uc;
        @(posedge clock) disable iff (rst)
        $past(ce && reqValid && hit[1] && rangeCtrl_q[`MTRC_HALF_W + `MTRC_UC_BIT]) |-> rspUncacheable;
    endproperty
    a_range1_uc: assert property (p_range1_uc) else $error("range one uncacheable bit ignored");

    property p_wc_type;
        @(posedge clock) disable iff (rst)
        $past(ce && reqValid && (|rangeWc) && !(|rangeUc)) |-> rspWriteCombine;
    endproperty
    a_wc_type: assert property (p_wc_type) else $error("combine bit not decoded");

    property p_msr_read;
        @(posedge clock) disable iff (rst)
        $past(ce && msrRead && !msrWrite && msrSel) |-> msrAck && (msrRdata == $past(rangeCtrl_q));
    endproperty
    a_msr_read: assert property (p_msr_read) else $error("register readback wrong");

    property p_ordering;
        @(posedge clock) disable iff (rst)
        $past(ce && reqValid && reqWrite && !globalOrderingDisable && speculativeOrderingDisable)
            |-> rspStrongOrder == !(rspUncacheable || rspWriteCombine);
    endproperty
    a_ordering: assert property (p_ordering) else $error("ordering exemption wrong");

    property p_write_next;
        @(posedge clock) disable iff (rst)
        ce && msrWrite && msrSel ##1 ce && reqValid |=> rspRangeHit == $past(expectHit);
    endproperty
    a_write_next: assert property (p_write_next) else $error("register write not used on next access");

endmodule : mtrc_range_checker

// *** rtl/mtrc_regs.svh ***
`ifndef MTRC_REGS_SVH
`define MTRC_REGS_SVH

// model-specific register address of the range control register
`define MTRC_MSR_ADDR 32'hc0000085
`define MTRC_CTRL_RESET 64'h0000000000000000

// layout of one 32-bit range descriptor
`define MTRC_HALF_W 32
`define MTRC_UC_BIT 0
`define MTRC_WC_BIT 1
`define MTRC_MASK_LSB 2
`define MTRC_BASE_LSB 17
`define MTRC_FIELD_W 15

// physical address slicing
`define MTRC_ADDR_LSB 17
`define MTRC_BLK_LSB 3
`define MTRC_LANE_BIT 2

`endif

// *** rtl/mtrc_pkg.sv ***
package mtrc_pkg;

    typedef enum logic [1:0] {
        MTRC_MT_NONE = 2'b00,
        MTRC_MT_WC = 2'b01,
        MTRC_MT_UC = 2'b10
    } mtrc_mtype_t;

    typedef enum logic {
        MTRC_MB_EMPTY = 1'b0,
        MTRC_MB_HOLD = 1'b1
    } mtrc_mb_state_t;

endpackage : mtrc_pkg

// *** rtl/mtrc_merge_buffer.sv ***
`timescale 1ns/1ps
`include "mtrc_regs.svh"

// 8-byte write merge buffer
module mtrc_merge_buffer (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic mergeEn,
    input wire logic flush,
    input wire logic [31:0] addr,
    input wire logic [3:0] be,
    input wire logic [31:0] data,
    output logic outValid,
    output logic [28:0] outAddr,
    output logic [63:0] outData,
    output logic [7:0] outBe
);
    import mtrc_pkg::*;

    mtrc_mb_state_t state_q, state_d;
    logic [28:0] blkAddr_q, blkAddr_d;
    logic [63:0] bufData_q, bufData_d;
    logic [7:0] bufBe_q, bufBe_d;
    logic outValid_d;
    logic [28:0] outAddr_d;
    logic [63:0] outData_d;
    logic [7:0] outBe_d;
    logic [7:0] laneBe;
    logic [63:0] laneData;
    logic [63:0] mergedData;
    logic sameBlk;

    assign laneBe = addr[`MTRC_LANE_BIT] ? {be, 4'h0} : {4'h0, be};
    assign laneData = {data, data};
    assign sameBlk = addr[31:`MTRC_BLK_LSB] == blkAddr_q;

    // per-byte merge of new lanes over held lanes
    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_lane
            assign mergedData[b*8 +: 8] = laneBe[b] ? laneData[b*8 +: 8] : bufData_q[b*8 +: 8];
        end
    endgenerate

    always_comb
    begin
        state_d = state_q;
        blkAddr_d = blkAddr_q;
        bufData_d = bufData_q;
        bufBe_d = bufBe_q;
        outValid_d = 1'b0;
        outAddr_d = outAddr;
        outData_d = outData;
        outBe_d = outBe;
        case (state_q)
            MTRC_MB_EMPTY:
            begin
                if (mergeEn)
                begin
                    state_d = MTRC_MB_HOLD;
                    blkAddr_d = addr[31:`MTRC_BLK_LSB];
                    bufData_d = laneData;
                    bufBe_d = laneBe;
                end
            end
            MTRC_MB_HOLD:
            begin
                if (mergeEn && sameBlk && !flush)
                begin
                    bufData_d = mergedData;
                    bufBe_d = bufBe_q | laneBe;
                end
                else if (mergeEn || flush)
                begin
                    // one bus write for everything merged so far
                    outValid_d = 1'b1;
                    outAddr_d = blkAddr_q;
                    outData_d = bufData_q;
                    outBe_d = bufBe_q;
                    state_d = MTRC_MB_EMPTY;
                    if (mergeEn)
                    begin
                        state_d = MTRC_MB_HOLD;
                        blkAddr_d = addr[31:`MTRC_BLK_LSB];
                        bufData_d = laneData;
                        bufBe_d = laneBe;
                    end
                end
            end
            default:
            begin
                state_d = MTRC_MB_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= MTRC_MB_EMPTY;
            blkAddr_q <= 29'h0;
            bufData_q <= 64'h0;
            bufBe_q <= 8'h0;
            outValid <= 1'b0;
            outAddr <= 29'h0;
            outData <= 64'h0;
            outBe <= 8'h0;
        end
        else if (ce)
        begin
            state_q <= state_d;
            blkAddr_q <= blkAddr_d;
            bufData_q <= bufData_d;
            bufBe_q <= bufBe_d;
            outValid <= outValid_d;
            outAddr <= outAddr_d;
            outData <= outData_d;
            outBe <= outBe_d;
        end
    end

    property p_emit_has_bytes;
        @(posedge clock) disable iff (rst)
        outValid && $past(ce) |-> (outBe != 8'h00) && $past(state_q == MTRC_MB_HOLD);
    endproperty
    a_emit_has_bytes: assert property (p_emit_has_bytes) else $error("merge write out with no bytes");

endmodule : mtrc_merge_buffer

// *** tb/mtrc_bus_sink.sv ***
`timescale 1ns/1ps

// far side of the merged bus write port, takes every write at once
module mtrc_bus_sink (
    input wire logic clock,
    input wire logic rst,
    input wire logic busWrValid,
    input wire logic [28:0] busWrAddr,
    input wire logic [63:0] busWrData,
    input wire logic [7:0] busWrBe,
    output logic [28:0] lastAddr,
    output logic [63:0] lastData,
    output logic [7:0] lastBe,
    output logic [7:0] writeCount
);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            lastAddr <= 29'h0;
            lastData <= 64'h0;
            lastBe <= 8'h0;
            writeCount <= 8'h0;
        end
        else if (busWrValid)
        begin
            lastAddr <= busWrAddr;
            lastData <= busWrData;
            lastBe <= busWrBe;
            writeCount <= writeCount + 8'h1;
        end
    end
endmodule : mtrc_bus_sink

// *** tb/mtrc_range_checker_tb_top.sv ***
`timescale 1ns/1ps
`include "mtrc_regs.svh"

module mtrc_range_checker_tb_top;
    import mtrc_pkg::*;
    // range 0 uncacheable 16M..32M, range 1 combining 8M above 1G
    localparam logic [63:0] CFG = 64'h4001ff02_0101fe01;
    logic clock = 1'b0;
    logic ce = 1'b1;
    logic rst = 1'b1;
    logic msrWrite = 1'b0;
    logic msrRead = 1'b0;
    logic [31:0] msrAddr = 32'h0;
    logic [63:0] msrWdata = 64'h0;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [31:0] reqAddr = 32'h0;
    logic [3:0] reqBe = 4'h0;
    logic [31:0] reqData = 32'h0;
    logic globalOrd = 1'b0;
    logic specOrd = 1'b0;
    logic mergeFlush = 1'b0;
    logic [63:0] msrRdata;
    logic msrAck;
    logic rspValid;
    mtrc_mtype_t rspType;
    logic rspUncacheable;
    logic rspWriteCombine;
    logic rspNoAllocate;
    logic rspMerged;
    logic rspStrongOrder;
    logic [1:0] rspRangeHit;
    logic busWrValid;
    logic [28:0] busWrAddr;
    logic [63:0] busWrData;
    logic [7:0] busWrBe;
    logic [28:0] lastAddr;
    logic [63:0] lastData;
    logic [7:0] lastBe;
    logic [7:0] writeCount;
    logic [5:0] rspVec;
    int failures = 0;
    int samples_checked = 0;

    assign rspVec = {rspValid, rspType, rspNoAllocate, rspRangeHit};

    always #25 clock = ~clock;

    mtrc_range_checker dut (.clock(clock), .rst(rst), .ce(ce), .msrWrite(msrWrite), .msrRead(msrRead),
        .msrAddr(msrAddr), .msrWdata(msrWdata), .msrRdata(msrRdata), .msrAck(msrAck), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqBe(reqBe), .reqData(reqData),
        .globalOrderingDisable(globalOrd), .speculativeOrderingDisable(specOrd), .mergeFlush(mergeFlush),
        .rspValid(rspValid), .rspType(rspType), .rspUncacheable(rspUncacheable),
        .rspWriteCombine(rspWriteCombine), .rspNoAllocate(rspNoAllocate), .rspMerged(rspMerged),
        .rspStrongOrder(rspStrongOrder), .rspRangeHit(rspRangeHit), .busWrValid(busWrValid),
        .busWrAddr(busWrAddr), .busWrData(busWrData), .busWrBe(busWrBe));

    mtrc_bus_sink sink (.clock(clock), .rst(rst), .busWrValid(busWrValid), .busWrAddr(busWrAddr),
        .busWrData(busWrData), .busWrBe(busWrBe), .lastAddr(lastAddr), .lastData(lastData),
        .lastBe(lastBe), .writeCount(writeCount));

    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task msr(input logic wr, input logic [31:0] a, input logic [63:0] d);
        @(posedge clock);
        msrWrite <= wr;
        msrRead <= !wr;
        msrAddr <= a;
        msrWdata <= d;
        @(posedge clock);
        msrWrite <= 1'b0;
        msrRead <= 1'b0;
        #1;
    endtask : msr

    task req(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqBe <= 4'hf;
        reqData <= d;
        @(posedge clock);
        reqValid <= 1'b0;
        reqWrite <= 1'b0;
        #1;
    endtask : req

    task test_regs;
        msr(1'b0, `MTRC_MSR_ADDR, 64'h0);
        chk(64'(msrAck), 64'h1, "read ack");
        chk(msrRdata, 64'h0, "reset value");
        msr(1'b1, `MTRC_MSR_ADDR, 64'ha5a5f00f_5a5a0ff0);
        chk(64'(msrAck), 64'h1, "write ack");
        msr(1'b0, `MTRC_MSR_ADDR, 64'h0);
        chk(msrRdata, 64'ha5a5f00f_5a5a0ff0, "readback");
        msr(1'b0, 32'hc0000086, 64'h0);
        chk(64'(msrAck), 64'h0, "unmapped read ack");
        chk(msrRdata, 64'h0, "unmapped read data");
        $display("test_regs done");
    endtask : test_regs

    task test_classify;
        msr(1'b1, `MTRC_MSR_ADDR, CFG);
        req(1'b0, 32'h01800000, 32'h0);
        chk(64'(rspVec), 64'h35, "uc read");
        chk(64'({rspUncacheable, rspWriteCombine}), 64'h2, "uc flags");
        req(1'b0, 32'h40400000, 32'h0);
        chk(64'(rspVec), 64'h2e, "wc read");
        chk(64'({rspUncacheable, rspWriteCombine}), 64'h1, "wc flags");
        req(1'b0, 32'h01000000, 32'h0);
        chk(64'(rspVec), 64'h35, "uc low edge");
        req(1'b0, 32'h01ffffff, 32'h0);
        chk(64'(rspVec), 64'h35, "uc high edge");
        req(1'b0, 32'h00ffffff, 32'h0);
        chk(64'(rspVec), 64'h20, "below uc");
        req(1'b0, 32'h02000000, 32'h0);
        chk(64'(rspVec), 64'h20, "above uc");
        req(1'b0, 32'h40800000, 32'h0);
        chk(64'(rspVec), 64'h20, "above wc");
        $display("test_classify done");
    endtask : test_classify

    task test_types;
        msr(1'b1, `MTRC_MSR_ADDR, 64'h00000003_00000002);
        req(1'b0, 32'h12345678, 32'h0);
        chk(64'(rspVec), 64'h37, "uc beats wc");
        msr(1'b1, `MTRC_MSR_ADDR, 64'h0);
        req(1'b0, 32'hfffe0000, 32'h0);
        chk(64'(rspVec), 64'h23, "no effect type");
        $display("test_types done");
    endtask : test_types

    task test_merge;
        logic [7:0] base;
        msr(1'b1, `MTRC_MSR_ADDR, CFG);
        base = writeCount;
        req(1'b1, 32'h40000000, 32'h11223344);
        chk(64'(rspMerged), 64'h1, "merged");
        req(1'b1, 32'h40000004, 32'h55667788);
        req(1'b0, 32'h40000000, 32'h0);
        @(posedge clock);
        #1;
        chk(64'(writeCount - base), 64'h1, "one bus write");
        chk(lastData, 64'h55667788_11223344, "merged data");
        chk(64'({lastAddr, lastBe}), 64'({29'h08000000, 8'hff}), "merged addr be");
        req(1'b1, 32'h40000008, 32'h0a0b0c0d);
        @(posedge clock);
        mergeFlush <= 1'b1;
        @(posedge clock);
        mergeFlush <= 1'b0;
        @(posedge clock);
        #1;
        chk(64'(writeCount - base), 64'h2, "flush write");
        chk(64'({lastAddr, lastBe}), 64'({29'h08000001, 8'h0f}), "flush addr be");
        chk(64'(lastData[31:0]), 64'h0a0b0c0d, "flush data");
        $display("test_merge done");
    endtask : test_merge

    task test_order;
        req(1'b1, 32'h01800000, 32'h1);
        chk(64'(rspStrongOrder), 64'h1, "uc ordered by default");
        @(posedge clock);
        specOrd <= 1'b1;
        req(1'b1, 32'h00100000, 32'h1);
        chk(64'(rspStrongOrder), 64'h1, "ordered normal");
        req(1'b1, 32'h01800000, 32'h1);
        chk(64'(rspStrongOrder), 64'h0, "uc not ordered");
        chk(64'(rspMerged), 64'h0, "uc write not merged");
        req(1'b1, 32'h40000010, 32'h1);
        chk(64'(rspStrongOrder), 64'h0, "wc not ordered");
        @(posedge clock);
        globalOrd <= 1'b1;
        req(1'b1, 32'h00100000, 32'h1);
        chk(64'(rspStrongOrder), 64'h0, "global off");
        $display("test_order done");
    endtask : test_order

    task test_freeze;
        @(posedge clock);
        ce <= 1'b0;
        msr(1'b1, `MTRC_MSR_ADDR, 64'h0);
        chk(64'(msrAck), 64'h0, "frozen write ignored");
        @(posedge clock);
        ce <= 1'b1;
        msr(1'b0, `MTRC_MSR_ADDR, 64'h0);
        chk(msrRdata, CFG, "frozen register kept");
        $display("test_freeze done");
    endtask : test_freeze

    task test_next;
        @(posedge clock);
        msrWrite <= 1'b1;
        msrAddr <= `MTRC_MSR_ADDR;
        msrWdata <= 64'h0;
        @(posedge clock);
        msrWrite <= 1'b0;
        reqValid <= 1'b1;
        reqWrite <= 1'b0;
        reqAddr <= 32'h01800000;
        @(posedge clock);
        reqValid <= 1'b0;
        #1;
        chk(64'(rspVec), 64'h23, "write used at next access");
        $display("test_next done");
    endtask : test_next

    initial
    begin
        repeat (5000) @(posedge clock);
        failures++;
        $display("ERROR at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial
    begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        test_regs();
        test_classify();
        test_types();
        test_merge();
        test_order();
        test_freeze();
        test_next();
        wrap_up();
    end
endmodule : mtrc_range_checker_tb_top
